// [swb_pkg.sv]
// Constants, types and helpers for the status word and SFR map block
package swb_pkg;
  localparam logic [7:0]  PSW_ADDR    = 8'hd0;
  localparam logic [7:0]  SYSC_ADDR   = 8'hb1;
  localparam logic [7:0]  PCON2_ADDR  = 8'h88;
  localparam logic [7:0]  PSW_RST     = 8'h00;
  localparam logic [7:0]  SYSC_RST    = 8'h21;
  localparam logic [7:0]  SYSC_MASK   = 8'h33;
  localparam logic [7:0]  PCON2_RST   = 8'h00;
  localparam logic [15:0] ONCHIP_EXTENDED_RAM_BASE   = 16'hfc00;
  localparam int          MAP_BIT     = 4;
  localparam int          CY_BIT      = 7;
  localparam int          HC_BIT      = 6;
  localparam int          UF0_BIT     = 5;
  localparam int          BSH_BIT     = 4;
  localparam int          BSL_BIT     = 3;
  localparam int          OV_BIT      = 2;
  localparam int          UF1_BIT     = 1;
  localparam int          PAR_BIT     = 0;
  localparam int          RST_MIN_OSC = 24;

  // Kind of memory access the core asks for
  typedef enum logic [3:0] {
    REQ_CODE     = 4'b0001,
    REQ_XDATA    = 4'b0010,
    REQ_DIRECT   = 4'b0100,
    REQ_INDIRECT = 4'b1000
  } swb_req_t;

  // Space the access lands in
  typedef enum logic [6:0] {
    TGT_NONE    = 7'b0000000,
    TGT_PROG    = 7'b0000001,
    TGT_EXT     = 7'b0000010,
    TGT_ONCHIP_EXTENDED_RAM    = 7'b0000100,
    TGT_IRAM    = 7'b0001000,
    TGT_SFR_STD = 7'b0010000,
    TGT_SFR_MAP = 7'b0100000,
    TGT_RSV     = 7'b1000000
  } swb_tgt_t;

  // Bit addressable SFR: upper half and low three address bits zero
  function automatic logic swb_bit_ok(input logic [7:0] a);
    swb_bit_ok = a[7] && (a[2:0] == 3'h0);
  endfunction : swb_bit_ok

  // Odd count of ones gives one
  function automatic logic swb_parity(input logic [7:0] v);
    swb_parity = ^v;
  endfunction : swb_parity
endpackage : swb_pkg

// [swb_rst_sync.sv]
// Two-stage synchroniser for the active low reset pin
`timescale 1ns/1ps
module swb_rst_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  output logic      o_rst_n
);
  typedef struct packed {
    logic s1;
    logic s2;
  } swb_rs_st_t;

  swb_rs_st_t st_ff;
  swb_rs_st_t nxt_st;

  // Assert at once, release after two edges
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = 1'b1;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rst_n = st_ff.s2;

  // Release is two edges after the pin rises
  rst_release_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(o_rst_n) |-> $past(i_arst_n, 2))
    else $error("reset released too early");
endmodule : swb_rst_sync

// [swb_space_dec.sv]
// Decoder of the four operand spaces and of the SFR map
`timescale 1ns/1ps
module swb_space_dec
  import swb_pkg::*;
(
  input  wire swb_req_t    i_space,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_alt_map,
  output swb_tgt_t         o_tgt
);
  // Direct upper half follows the map bit; indirect always hits RAM
  always_comb begin
    unique case (i_space)
      REQ_CODE:     o_tgt = TGT_PROG;
      REQ_XDATA:    o_tgt = (i_addr >= ONCHIP_EXTENDED_RAM_BASE) ? TGT_ONCHIP_EXTENDED_RAM : TGT_EXT;
      REQ_DIRECT: begin
        if (i_addr[7]) begin
          o_tgt = i_alt_map ? TGT_SFR_MAP : TGT_SFR_STD;
        end else begin
          o_tgt = TGT_IRAM;
        end
      end
      REQ_INDIRECT: o_tgt = TGT_IRAM;
      default:      o_tgt = TGT_NONE;
    endcase
  end
endmodule : swb_space_dec

// [swb_status_map.sv]
// Status word, system control map bit and second power control register
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module swb_status_map
  import swb_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [7:0]       o_rdata,
  input  wire logic [7:0]  i_bit_addr,
  input  wire logic        i_bit_wval,
  input  wire logic        i_bit_wr,
  input  wire logic        i_bit_rd,
  output logic             o_bit_rval,
  input  wire logic [7:0]  i_acc,
  input  wire logic        i_instr_done,
  input  wire logic        i_arith_we,
  input  wire logic        i_cy,
  input  wire logic        i_ov,
  input  wire logic        i_hc_we,
  input  wire logic        i_hc,
  input  wire swb_req_t    i_req_space,
  input  wire logic [15:0] i_req_addr,
  output swb_tgt_t         o_tgt,
  output logic [7:0]       o_psw,
  output logic [7:0]       o_bank_base,
  output logic             o_alt_map,
  output logic [7:0]       o_pcon2,
  output logic             o_rst_n
);
  typedef struct packed {
    logic [7:0] processor_status_word;
    logic [7:0] sysc;
    logic [7:0] pcon2;
    logic [7:0] rdata;
    logic       bit_rval;
    logic [7:0] bank;
    swb_tgt_t   tgt;
    logic       rst_n;
  } swb_top_st_t;

  swb_top_st_t st_ff;
  swb_top_st_t nxt_st;
  logic        rst_n;
  swb_tgt_t    dec_tgt;
  logic [7:0]  bit_byte;
  logic [2:0]  bit_idx;
  logic        std_map;
  logic [7:0]  bit_src;

  // Reset pin synchroniser
  swb_rst_sync u_rst (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .o_rst_n   (rst_n)
  );

  // Space and map decode of core accesses
  swb_space_dec u_dec (
    .i_space   (i_req_space),
    .i_addr    (i_req_addr),
    .i_alt_map (st_ff.sysc[MAP_BIT]),
    .o_tgt     (dec_tgt)
  );

  // Byte read mux; control register is visible in both areas
  function automatic logic [7:0] rd_mux(input swb_top_st_t s, input logic [7:0] a);
    logic std;
    std    = !s.sysc[MAP_BIT];
    rd_mux = 8'h00;
    if (a == SYSC_ADDR) begin
      rd_mux = s.sysc & SYSC_MASK;
    end else if (std && a == PSW_ADDR) begin
      rd_mux = s.processor_status_word;
    end else if (!std && a == PCON2_ADDR) begin
      rd_mux = s.pcon2;
    end
  endfunction : rd_mux

  assign bit_byte = {i_bit_addr[7:3], 3'h0};
  assign bit_idx  = i_bit_addr[2:0];
  assign std_map  = !st_ff.sysc[MAP_BIT];
  assign bit_src  = rd_mux(st_ff, bit_byte);

  // Next state: software writes first, hardware flag updates win
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rst_n = 1'b1;
    if (i_wr) begin
      if (i_addr == SYSC_ADDR) begin
        nxt_st.sysc = i_wdata & SYSC_MASK;
      end else if (std_map && i_addr == PSW_ADDR) begin
        nxt_st.processor_status_word[7:1] = i_wdata[7:1];
      end else if (!std_map && i_addr == PCON2_ADDR) begin
        nxt_st.pcon2 = i_wdata;
      end
    end
    if (i_bit_wr && swb_bit_ok(bit_byte)) begin
      if (std_map && bit_byte == PSW_ADDR && bit_idx != 3'(PAR_BIT)) begin
        nxt_st.processor_status_word[bit_idx] = i_bit_wval;
      end else if (!std_map && bit_byte == PCON2_ADDR) begin
        nxt_st.pcon2[bit_idx] = i_bit_wval;
      end
    end
    if (i_arith_we) begin
      nxt_st.processor_status_word[CY_BIT] = i_cy;
      nxt_st.processor_status_word[OV_BIT] = i_ov;
    end
    if (i_hc_we) begin
      nxt_st.processor_status_word[HC_BIT] = i_hc;
    end
    if (i_instr_done) begin
      nxt_st.processor_status_word[PAR_BIT] = swb_parity(i_acc);
    end
    nxt_st.bank     = {3'h0, nxt_st.processor_status_word[BSH_BIT], nxt_st.processor_status_word[BSL_BIT], 3'h0};
    nxt_st.rdata    = i_rd ? rd_mux(st_ff, i_addr) : 8'h00;
    nxt_st.bit_rval = 1'b0;
    if (i_bit_rd && swb_bit_ok(bit_byte)) begin
      nxt_st.bit_rval = bit_src[bit_idx];
    end
    nxt_st.tgt = dec_tgt;
  end

  // State register on the synchronised reset
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff       <= '0;
      st_ff.processor_status_word   <= PSW_RST;
      st_ff.sysc  <= SYSC_RST;
      st_ff.pcon2 <= PCON2_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign o_rdata     = st_ff.rdata;
  assign o_bit_rval  = st_ff.bit_rval;
  assign o_tgt       = st_ff.tgt;
  assign o_psw       = st_ff.processor_status_word;
  assign o_bank_base = st_ff.bank;
  assign o_alt_map   = st_ff.sysc[MAP_BIT];
  assign o_pcon2     = st_ff.pcon2;
  assign o_rst_n     = st_ff.rst_n;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence psw_byte_rd_s;
    i_rd && i_addr == PSW_ADDR && !o_alt_map;
  endsequence

  sequence no_sysc_wr_s;
    !(i_wr && i_addr == SYSC_ADDR);
  endsequence

  sequence no_psw_sw_s;
    !(i_wr && i_addr == PSW_ADDR) && !(i_bit_wr && i_bit_addr[7:3] == PSW_ADDR[7:3]);
  endsequence

  bank_base_a: assert property (o_bank_base == {3'h0, o_psw[BSH_BIT], o_psw[BSL_BIT], 3'h0})
    else $error("bank base does not match select bits");

  parity_upd_a: assert property (i_instr_done |=> o_psw[PAR_BIT] == ^$past(i_acc))
    else $error("parity flag not updated");

  parity_hold_a: assert property (!i_instr_done |=> $stable(o_psw[PAR_BIT]))
    else $error("parity flag moved without instruction end");

  arith_flags_a: assert property (i_arith_we |=> o_psw[CY_BIT] == $past(i_cy) && o_psw[OV_BIT] == $past(i_ov))
    else $error("carry or overflow not taken");

  half_carry_a: assert property (i_hc_we |=> o_psw[HC_BIT] == $past(i_hc))
    else $error("half carry not taken");

  psw_read_a: assert property (psw_byte_rd_s |=> o_rdata == $past(o_psw))
    else $error("status word read wrong");

  map_route_a: assert property (i_req_space == REQ_DIRECT && i_req_addr[7]
    |=> o_tgt == ($past(o_alt_map) ? TGT_SFR_MAP : TGT_SFR_STD))
    else $error("direct SFR access misrouted");

  map_keep_a: assert property (no_sysc_wr_s |=> $stable(o_alt_map))
    else $error("map bit changed without write");

  bit_write_a: assert property (i_bit_wr && i_bit_addr == {PSW_ADDR[7:3], 3'(UF0_BIT)} && !o_alt_map
    |=> o_psw[UF0_BIT] == $past(i_bit_wval))
    else $error("bit write to status word lost");

  indirect_a: assert property (i_req_space == REQ_INDIRECT |=> o_tgt == TGT_IRAM)
    else $error("indirect access left internal RAM");

  user_flags_a: assert property (no_psw_sw_s |=> $stable(o_psw[UF0_BIT]) && $stable(o_psw[UF1_BIT]))
    else $error("user flag changed by hardware");

  mapped_only_a: assert property (i_rd && o_alt_map && i_addr == PSW_ADDR |=> o_rdata == 8'h00)
    else $error("standard register seen in mapped area");

  // Byte read of the mapped power control register
  sequence pcon2_byte_rd_s;
    i_rd && i_addr == PCON2_ADDR && o_alt_map;
  endsequence

  // No software access that may touch the mapped power control register
  sequence no_pcon2_sw_s;
    !(i_wr && i_addr == PCON2_ADDR) && !(i_bit_wr && i_bit_addr[7:3] == PCON2_ADDR[7:3]);
  endsequence

  // Read data stands one cycle only
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside its cycle");

  // Control register reads its map bit and zero reserved bits
  sysc_read_a: assert property (i_rd && i_addr == SYSC_ADDR
    |=> o_rdata[MAP_BIT] == $past(o_alt_map) && (o_rdata & ~SYSC_MASK) == 8'h00)
    else $error("control register read wrong");

  // Mapped register readable with the map bit set
  pcon2_read_a: assert property (pcon2_byte_rd_s |=> o_rdata == $past(o_pcon2))
    else $error("mapped register read wrong");

  // Mapped register hidden with the map bit clear
  pcon2_hidden_a: assert property (i_rd && i_addr == PCON2_ADDR && !o_alt_map |=> o_rdata == 8'h00)
    else $error("mapped register seen in standard area");

  // Addresses this block does not hold read as zero
  read_none_a: assert property (i_rd && i_addr != SYSC_ADDR && i_addr != PSW_ADDR && i_addr != PCON2_ADDR
    |=> o_rdata == 8'h00)
    else $error("unheld address read nonzero");

  // Map bit follows a software write
  map_write_a: assert property (i_wr && i_addr == SYSC_ADDR |=> o_alt_map == $past(i_wdata[MAP_BIT]))
    else $error("map bit write lost");

  // Byte write to the status word in the standard area
  psw_write_a: assert property (i_wr && i_addr == PSW_ADDR && !o_alt_map && !i_bit_wr && !i_arith_we && !i_hc_we
    |=> o_psw[7:1] == $past(i_wdata[7:1]))
    else $error("status word write lost");

  // Status word write refused in the mapped area
  psw_locked_a: assert property (i_wr && i_addr == PSW_ADDR && o_alt_map && !i_bit_wr && !i_arith_we && !i_hc_we
    |=> o_psw[7:1] == $past(o_psw[7:1]))
    else $error("status word written in mapped area");

  // Byte write to the mapped register
  pcon2_write_a: assert property (i_wr && i_addr == PCON2_ADDR && o_alt_map && !i_bit_wr
    |=> o_pcon2 == $past(i_wdata))
    else $error("mapped register write lost");

  // Mapped register keeps its value without software access
  pcon2_keep_a: assert property (no_pcon2_sw_s |=> $stable(o_pcon2))
    else $error("mapped register changed by itself");

  // Parity bit ignores bit writes
  par_write_a: assert property (i_bit_wr && i_bit_addr == PSW_ADDR && !i_instr_done
    |=> $stable(o_psw[PAR_BIT]))
    else $error("parity flag written by software");

  // Bit read of the status word
  bit_read_a: assert property (i_bit_rd && !o_alt_map && i_bit_addr[7:3] == PSW_ADDR[7:3]
    |=> o_bit_rval == $past(o_psw[i_bit_addr[2:0]]))
    else $error("status word bit read wrong");

  // Bit read of the mapped register
  bit_map_rd_a: assert property (i_bit_rd && o_alt_map && i_bit_addr[7:3] == PCON2_ADDR[7:3]
    |=> o_bit_rval == $past(o_pcon2[i_bit_addr[2:0]]))
    else $error("mapped register bit read wrong");

  // Bit read value stands one cycle only
  bit_idle_a: assert property (!i_bit_rd |=> !o_bit_rval)
    else $error("bit value outside its cycle");

  // Bit addresses below the SFR area read zero
  bit_refused_a: assert property (i_bit_rd && !i_bit_addr[7] |=> !o_bit_rval)
    else $error("bit read below SFR area nonzero");

  // Direct accesses below 80h land in internal RAM
  direct_low_a: assert property (i_req_space == REQ_DIRECT && !i_req_addr[7] |=> o_tgt == TGT_IRAM)
    else $error("direct low access misrouted");

  // Code fetches land in program memory
  code_space_a: assert property (i_req_space == REQ_CODE |=> o_tgt == TGT_PROG)
    else $error("code access misrouted");

  // External data split between on-chip extended RAM and external memory
  xdata_space_a: assert property (i_req_space == REQ_XDATA
    |=> o_tgt == (($past(i_req_addr) >= ONCHIP_EXTENDED_RAM_BASE) ? TGT_ONCHIP_EXTENDED_RAM : TGT_EXT))
    else $error("external data access misrouted");

  // Carry and overflow move only on arithmetic or software writes
  carry_keep_a: assert property (!i_arith_we && !(i_wr && i_addr == PSW_ADDR)
    && !(i_bit_wr && i_bit_addr[7:3] == PSW_ADDR[7:3]) |=> $stable(o_psw[CY_BIT]) && $stable(o_psw[OV_BIT]))
    else $error("carry or overflow moved by itself");

  // Half carry moves only on BCD updates or software writes
  half_keep_a: assert property (!i_hc_we && !(i_wr && i_addr == PSW_ADDR)
    && !(i_bit_wr && i_bit_addr[7:3] == PSW_ADDR[7:3]) |=> $stable(o_psw[HC_BIT]))
    else $error("half carry moved by itself");

  // Bank base is one of the four bank starts
  bank_range_a: assert property ((o_bank_base & 8'he7) == 8'h00)
    else $error("bank base out of range");

  // Reset flag high once the internal reset has been released
  rst_flag_a: assert property ($past(rst_n) |-> o_rst_n)
    else $error("reset flag low after release");
endmodule : swb_status_map

// [tb_top.sv]
// Self-checking testbench for the status word and SFR map block
`timescale 1ns/1ps
module tb_top
  import swb_pkg::*;
;
  logic           sys_clk = 1'b0;
  logic           arst_n  = 1'b0;
  logic           wr = 1'b0, rd = 1'b0, bwr = 1'b0, brd = 1'b0, bwv = 1'b0;
  logic           idone = 1'b0, awe = 1'b0, hwe = 1'b0, cy = 1'b0, ov = 1'b0, hc = 1'b0;
  logic [7:0]     addr = 8'h00, wd = 8'h00, baddr = 8'h80, acc = 8'h00, v;
  logic [15:0]    raddr = 16'h0000;
  swb_req_t       sp = REQ_CODE;
  logic [7:0]     rdata, processor_status_word, bank, pcon2;
  logic           brv, amap, rstq;
  swb_tgt_t       tgt;
  int             miscompares = 0;
  int             samples_checked = 0;

  swb_status_map i_dut (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_bit_addr(baddr), .i_bit_wval(bwv), .i_bit_wr(bwr), .i_bit_rd(brd),
    .o_bit_rval(brv), .i_acc(acc), .i_instr_done(idone), .i_arith_we(awe), .i_cy(cy), .i_ov(ov),
    .i_hc_we(hwe), .i_hc(hc), .i_req_space(sp), .i_req_addr(raddr), .o_tgt(tgt), .o_psw(processor_status_word),
    .o_bank_base(bank), .o_alt_map(amap), .o_pcon2(pcon2), .o_rst_n(rstq));

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write, state visible after the taking edge
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask : wreg

  // One-cycle read, data sampled in the following cycle only
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg

  // Single-bit write or read on the bit port
  task automatic bitop(input logic [7:0] a, input logic w, input logic b);
    @(posedge sys_clk);
    bwr <= w;
    brd <= ~w;
    baddr <= a;
    bwv <= b;
    @(posedge sys_clk);
    bwr <= 1'b0;
    brd <= 1'b0;
    #1;
  endtask : bitop

  // Reset values, then a mid-run reset and its release sequence
  task automatic t_reset;
    chk(processor_status_word, PSW_RST); chk({7'h00, amap}, 8'h00); chk({7'h00, rstq}, 8'h01);
    rreg(SYSC_ADDR, v); chk(v, SYSC_RST);
    wreg(PSW_ADDR, 8'h18);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    #1;
    chk(processor_status_word, 8'h00); chk(bank, 8'h00);
    repeat (RST_MIN_OSC) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({7'h00, rstq}, 8'h00);
    @(posedge sys_clk);
    #1;
    chk({7'h00, rstq}, 8'h01);
    $display("test reset done");
  endtask : t_reset

  // Banks, user flags and the read-only parity bit through byte and bit ports
  task automatic t_psw;
    for (int k = 0; k < 4; k++) begin
      wreg(PSW_ADDR, 8'(k << 3));
      chk(bank, 8'(k * 8));
    end
    wreg(PSW_ADDR, 8'h23);
    rreg(PSW_ADDR, v); chk(v, 8'h22);
    @(posedge sys_clk);
    #1;
    chk(processor_status_word, 8'h22);
    bitop(8'hd5, 1'b1, 1'b0); chk(processor_status_word, 8'h02);
    bitop(8'hd0, 1'b1, 1'b1); chk(processor_status_word, 8'h02);
    bitop(8'hd3, 1'b1, 1'b1); chk(bank, 8'h08);
    bitop(8'hd1, 1'b0, 1'b0); chk({7'h00, brv}, 8'h01);
    $display("test psw done");
  endtask : t_psw

  // Parity after each instruction, arithmetic and BCD flags
  task automatic t_flags;
    logic [7:0] av[5] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hfe};
    wreg(PSW_ADDR, 8'h00);
    foreach (av[i]) begin
      @(posedge sys_clk);
      idone <= 1'b1;
      acc <= av[i];
      @(posedge sys_clk);
      idone <= 1'b0;
      #1;
      chk({7'h00, processor_status_word[0]}, {7'h00, ^av[i]});
    end
    @(posedge sys_clk);
    awe <= 1'b1;
    cy <= 1'b1;
    ov <= 1'b1;
    hwe <= 1'b1;
    hc <= 1'b1;
    @(posedge sys_clk);
    awe <= 1'b0;
    hwe <= 1'b0;
    #1;
    chk(processor_status_word & 8'hc4, 8'hc4);
    $display("test flags done");
  endtask : t_flags

  // Map bit steering and persistence; reserved control bits are written but masked out of the check
  task automatic t_map;
    wreg(SYSC_ADDR, 8'hff);
    rreg(SYSC_ADDR, v); chk(v & SYSC_MASK, SYSC_MASK);
    chk({7'h00, amap}, 8'h01);
    rreg(PSW_ADDR, v); chk(v, 8'h00);
    wreg(PCON2_ADDR, 8'h5a);
    rreg(PCON2_ADDR, v); chk(v, 8'h5a);
    bitop(8'h8f, 1'b1, 1'b1); chk(pcon2, 8'hda);
    bitop(8'h8f, 1'b0, 1'b0); chk({7'h00, brv}, 8'h01);
    bitop(8'hd2, 1'b0, 1'b0); chk({7'h00, brv}, 8'h00);
    repeat (10) @(posedge sys_clk);
    #1;
    chk({7'h00, amap}, 8'h01);
    wreg(SYSC_ADDR, 8'h21);
    rreg(PCON2_ADDR, v); chk(v, 8'h00);
    rreg(PSW_ADDR, v); chk(v, 8'hc5);
    rreg(8'h81, v); chk(v, 8'h00);
    chk(pcon2, 8'hda);
    $display("test map done");
  endtask : t_map

  // Space decode under one map setting, chosen by m
  task automatic t_dec(input logic m);
    swb_req_t  s[6] = '{REQ_CODE, REQ_XDATA, REQ_XDATA, REQ_DIRECT, REQ_DIRECT, REQ_INDIRECT};
    logic [15:0] a[6] = '{16'h1234, 16'h0100, 16'hfc00, 16'h0040, 16'h0090, 16'h00c0};
    swb_tgt_t  e[6] = '{TGT_PROG, TGT_EXT, TGT_ONCHIP_EXTENDED_RAM, TGT_IRAM, TGT_SFR_STD, TGT_IRAM};
    wreg(SYSC_ADDR, {3'h0, m, 4'h1});
    foreach (s[i]) begin
      @(posedge sys_clk);
      sp <= s[i];
      raddr <= a[i];
      @(posedge sys_clk);
      #1;
      chk({1'b0, tgt}, (m && i == 4) ? {1'b0, TGT_SFR_MAP} : {1'b0, e[i]});
    end
    @(posedge sys_clk);
    sp <= swb_req_t'(4'b0011);
    @(posedge sys_clk);
    #1;
    chk({1'b0, tgt}, {1'b0, TGT_NONE});
    $display("test decode done");
  endtask : t_dec

  // Watchdog
  initial begin
    #(40 * 3000);
    miscompares++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_reset();
    @(posedge sys_clk);
    t_psw();
    t_flags();
    t_map();
    t_dec(1'b0);
    t_dec(1'b1);
    close_out();
  end
endmodule : tb_top
